// ### hw/sensor_event_pkg.sv
/*
 * Constants for the sensor event status block: register offsets, field
 * positions, reset values and mode encodings.
 * Assumes a host register port of 7-bit address and 8-bit data.
 */
package sensor_event_pkg;
    localparam logic [6:0] OFF_DATA_FIRST = 7'h01;
    localparam logic [6:0] OFF_TRIG_EN = 7'h0a;
    localparam logic [6:0] OFF_SYS_MODE = 7'h0b;
    localparam logic [6:0] OFF_INT_SRC = 7'h0c;
    localparam logic [6:0] OFF_MAG_INT_SRC = 7'h5e;
    localparam int DATA_BURST_BYTES = 12;
    localparam logic [6:0] OFF_DATA_LAST = 7'h0c;
    localparam logic [7:0] TRIG_EN_RESET = 8'h00;
    localparam logic [7:0] TRIG_EN_MASK = 8'h3e;
    localparam int TRIG_VECM_BIT = 1;
    localparam int TRIG_FFMT_BIT = 2;
    localparam int TRIG_PULSE_BIT = 3;
    localparam int TRIG_ORIENT_BIT = 4;
    localparam int TRIG_TRANS_BIT = 5;
    localparam int SRC_DRDY_BIT = 0;
    localparam int SRC_VECM_BIT = 1;
    localparam int SRC_FFMT_BIT = 2;
    localparam int SRC_PULSE_BIT = 3;
    localparam int SRC_ORIENT_BIT = 4;
    localparam int SRC_TRANS_BIT = 5;
    localparam int SRC_FIFO_BIT = 6;
    localparam int SRC_ASLP_BIT = 7;
    localparam logic [4:0] GATE_AGE_MAX = 5'h1f;
    localparam int FIFO_DEPTH = 32;
    localparam logic [1:0] FIFO_MODE_TRIGGER = 2'h3;
    localparam logic [1:0] SENSOR_ACCEL = 2'h0;
    localparam logic [1:0] SENSOR_MAG = 2'h1;
    localparam logic [1:0] SENSOR_HYBRID = 2'h3;
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_WAKE = 2'b01,
        MODE_SLEEP = 2'b10
    } sys_mode_t;
endpackage : sensor_event_pkg

// ### hw/gate_error_age.sv
/*
 * Gate error flag and its age counter in output-data-rate periods.
 * Assumes odr_tick is a one-cycle pulse once per data period.
 */
`timescale 1ns/1ps
`default_nettype none
module gate_error_age
    import sensor_event_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic gate_error_evt,
    input wire logic fifo_empty,
    input wire logic odr_tick,
    output logic gate_error,
    output logic [4:0] gate_age
);
    typedef struct packed {
        logic flag;
        logic [4:0] age;
    } age_state_t;

    age_state_t state_r;
    age_state_t state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        if (gate_error_evt)
        begin
            state_nxt.flag = 1'b1; // [RULE3]
        end
        else if (fifo_empty)
        begin
            state_nxt.flag = 1'b0; // [RULE3]
        end
        if (!state_nxt.flag)
        begin
            state_nxt.age = 5'h00; // [RULE4]
        end
        else if (state_r.flag && odr_tick && state_r.age != GATE_AGE_MAX)
        begin
            state_nxt.age = state_r.age + 5'h01; // [RULE22]
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign gate_error = state_r.flag;
    assign gate_age = state_r.age;

    age_sat_a: assert property (@(posedge clock) disable iff (!arst_n)
        (gate_age == GATE_AGE_MAX && gate_error && !fifo_empty) |=> gate_age == GATE_AGE_MAX)
        else $error("gate age left its ceiling"); // [RULE22]
    age_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
        !gate_error |-> gate_age == 5'h00)
        else $error("gate age nonzero without flag"); // [RULE4]
endmodule : gate_error_age
`default_nettype wire

// ### hw/sensor_event_status_regs.sv
/*
 * Interrupt status summary, FIFO trigger enables and system mode register.
 * Assumes detectors give level event flags, reads and writes are one-cycle
 * strobes with address, and the FIFO reports count, overflow and watermark.
 */
// Notes on behaviour
// [RULE1] Trigger mode: an enabled event flag gates the FIFO, keeping up to 32 samples.
// [RULE2] Trigger enables: transient, orientation, pulse, freefall, vector bits 5..1; reset zero.
// [RULE3] Gate error flag sets on error, clears only once the FIFO is empty.
// [RULE4] Five-bit age counts data periods since gate error, zero when cleared.
// [RULE5] Mode field reports standby 00, wake 01, sleep 10; resets to standby.
// [RULE6] Auto-sleep bit sets on a mode-changing event, clears on mode register read.
// [RULE7] Wake to sleep after inactivity count; sleep to wake on enabled wake event.
// [RULE8] Summary read clears only the vector-magnitude bit; others by own source read.
// [RULE9] FIFO bit sets on overflow or watermark, clears on FIFO status read.
// [RULE10] Transient bit follows enabled event-active flag; cleared by transient source read.
// [RULE11] Orientation bit follows enabled new-change flag; cleared by orientation detail read.
// [RULE12] Pulse bit follows enabled pulse flag; cleared by pulse source read.
// [RULE13] Freefall bit follows enabled active flag; cleared by freefall source read.
// [RULE14] Data-ready flags accel, magnetic, or either data by sensor mode.
// [RULE15] Data-ready clears on accel data read, or magnetic data read otherwise.
// [RULE16] Hybrid auto-increment: 12-byte burst from address 0x01 covers all data.
// [RULE17] Magnetic event flags live in their own register at 0x5e.
// [RULE18] Summary bits: aslp, fifo, trans, orient, pulse, ffmt, vecm, drdy.
// [RULE19] Host should read the mode register to track auto-sleep state.
// [RULE20] After a FIFO status read, next sample re-sets the bit if condition holds.
// [RULE21] FIFO mode 2'b11 is trigger mode; watermark then means trigger seen.
// [RULE22] Gate age saturates at 31 while the flag holds.
`timescale 1ns/1ps
`default_nettype none
module sensor_event_status_regs
    import sensor_event_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] mag_int_flags,
    input wire logic active_en,
    input wire logic aslp_en,
    input wire logic [7:0] aslp_count,
    input wire logic odr_tick,
    input wire logic activity,
    input wire logic wake_event,
    input wire logic [1:0] fifo_mode,
    input wire logic fifo_overflow,
    input wire logic fifo_watermark,
    input wire logic fifo_sample_in,
    input wire logic [5:0] fifo_count,
    input wire logic gate_error_evt,
    input wire logic [1:0] sensor_mode,
    input wire logic hyb_autoinc,
    input wire logic accel_new,
    input wire logic mag_new,
    input wire logic accel_data_rd,
    input wire logic mag_data_rd,
    input wire logic trans_event_active,
    input wire logic trans_int_en,
    input wire logic trans_src_rd,
    input wire logic orient_new_change,
    input wire logic orient_int_en,
    input wire logic orient_detail_reg_rd,
    input wire logic pulse_event_active,
    input wire logic pulse_int_en,
    input wire logic pulse_src_rd,
    input wire logic ffmt_event_active,
    input wire logic ffmt_int_en,
    input wire logic ffmt_src_rd,
    input wire logic vecm_event,
    input wire logic vecm_int_en,
    input wire logic fifo_status_rd,
    output logic fifo_gated,
    output logic trigger_seen,
    output logic sleep_rate_sel,
    output logic [6:0] burst_next_addr
);
    typedef struct packed {
        logic [7:0] trig_en;
        sys_mode_t mode;
        logic [7:0] idle_cnt;
        logic aslp;
        logic fifo;
        logic trans;
        logic orient;
        logic pulse;
        logic ffmt;
        logic vecm;
        logic drdy;
        logic fifo_cond_pend;
        logic gated;
        logic trig_seen;
        logic sleep_sel;
        logic [7:0] rdata;
        logic [6:0] next_addr;
    } regs_state_t;

    regs_state_t st_r;
    regs_state_t st_nxt;
    logic gate_error;
    logic [4:0] gate_age;
    logic [7:0] src_view;
    logic [7:0] trig_flags;
    logic trig_hit;
    logic fifo_cond;
    logic drdy_set;
    logic drdy_clr;
    logic rd_mode;
    logic rd_src;

    gate_error_age u_gate_age (
        .clock(clock),
        .arst_n(arst_n),
        .gate_error_evt(gate_error_evt),
        .fifo_empty(fifo_count == 6'h00),
        .odr_tick(odr_tick),
        .gate_error(gate_error),
        .gate_age(gate_age)
    );

    assign src_view = {st_r.aslp, st_r.fifo, st_r.trans, st_r.orient,
                       st_r.pulse, st_r.ffmt, st_r.vecm, st_r.drdy}; // [RULE18]
    assign trig_flags = {2'b00, st_r.trans, st_r.orient, st_r.pulse, st_r.ffmt,
                         st_r.vecm, 1'b0};
    assign trig_hit = |(trig_flags & st_r.trig_en); // [RULE1]
    assign fifo_cond = fifo_overflow | fifo_watermark;
    assign rd_mode = reg_rd && reg_addr == OFF_SYS_MODE;
    assign rd_src = reg_rd && reg_addr == OFF_INT_SRC;

    always_comb
    begin
        drdy_set = 1'b0;
        drdy_clr = 1'b0;
        case (sensor_mode) // [RULE14] [RULE15]
            SENSOR_ACCEL:
            begin
                drdy_set = accel_new;
                drdy_clr = accel_data_rd;
            end
            SENSOR_MAG:
            begin
                drdy_set = mag_new;
                drdy_clr = mag_data_rd;
            end
            SENSOR_HYBRID:
            begin
                drdy_set = accel_new | mag_new;
                drdy_clr = mag_data_rd;
            end
            default:
            begin
                drdy_set = accel_new;
                drdy_clr = accel_data_rd;
            end
        endcase
    end

    always_comb
    begin
        st_nxt = st_r;
        if (reg_wr && reg_addr == OFF_TRIG_EN)
        begin
            st_nxt.trig_en = reg_wdata & TRIG_EN_MASK; // [RULE2]
        end
        // Mode machine; sets win over read clears below
        case (st_r.mode)
            MODE_STANDBY:
            begin
                if (active_en)
                begin
                    st_nxt.mode = MODE_WAKE;
                    st_nxt.idle_cnt = 8'h00;
                end
            end
            MODE_WAKE:
            begin
                if (!active_en)
                begin
                    st_nxt.mode = MODE_STANDBY;
                end
                else if (activity || !aslp_en)
                begin
                    st_nxt.idle_cnt = 8'h00;
                end
                else if (odr_tick)
                begin
                    if (st_r.idle_cnt > aslp_count)
                    begin
                        st_nxt.mode = MODE_SLEEP; // [RULE7]
                        st_nxt.aslp = 1'b1;
                    end
                    else
                    begin
                        st_nxt.idle_cnt = st_r.idle_cnt + 8'h01;
                    end
                end
            end
            MODE_SLEEP:
            begin
                if (!active_en)
                begin
                    st_nxt.mode = MODE_STANDBY;
                end
                else if (wake_event)
                begin
                    st_nxt.mode = MODE_WAKE; // [RULE7]
                    st_nxt.idle_cnt = 8'h00;
                    st_nxt.aslp = 1'b1;
                end
            end
            default:
            begin
                st_nxt.mode = MODE_STANDBY;
            end
        endcase
        st_nxt.sleep_sel = st_nxt.mode == MODE_SLEEP; // [RULE7]
        if (rd_mode && st_nxt.mode == st_r.mode)
        begin
            st_nxt.aslp = 1'b0; // [RULE6]
        end
        // FIFO bit: cleared by status read, re-armed by the next sample;
        // a sample in the read cycle wins, so that event is not lost
        if (fifo_status_rd && !(fifo_cond && fifo_sample_in))
        begin
            st_nxt.fifo = 1'b0; // [RULE9]
            st_nxt.fifo_cond_pend = 1'b1;
        end
        else if (fifo_cond && (!st_r.fifo_cond_pend || fifo_sample_in))
        begin
            st_nxt.fifo = 1'b1; // [RULE9] [RULE20]
            st_nxt.fifo_cond_pend = 1'b0;
        end
        else if (!fifo_cond)
        begin
            st_nxt.fifo_cond_pend = 1'b0;
        end
        st_nxt.trans = (trans_event_active && trans_int_en) || (st_r.trans && !trans_src_rd); // [RULE10]
        st_nxt.orient = (orient_new_change && orient_int_en)
                        || (st_r.orient && !orient_detail_reg_rd); // [RULE11]
        st_nxt.pulse = (pulse_event_active && pulse_int_en) || (st_r.pulse && !pulse_src_rd); // [RULE12]
        st_nxt.ffmt = (ffmt_event_active && ffmt_int_en) || (st_r.ffmt && !ffmt_src_rd); // [RULE13]
        st_nxt.vecm = (vecm_event && vecm_int_en) || (st_r.vecm && !rd_src); // [RULE8]
        st_nxt.drdy = drdy_set || (st_r.drdy && !drdy_clr); // [RULE15]
        // Trigger gating; leaving trigger mode releases the FIFO
        if (fifo_mode != FIFO_MODE_TRIGGER)
        begin
            st_nxt.gated = 1'b0;
            st_nxt.trig_seen = 1'b0;
        end
        else if (trig_hit)
        begin
            st_nxt.gated = 1'b1; // [RULE1] [RULE21]
            st_nxt.trig_seen = 1'b1;
        end
        // Read data registered, so answers come one cycle after the strobe
        st_nxt.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                OFF_TRIG_EN: st_nxt.rdata = st_r.trig_en;
                OFF_SYS_MODE: st_nxt.rdata = {gate_error, gate_age, st_r.mode}; // [RULE5]
                OFF_INT_SRC: st_nxt.rdata = src_view; // [RULE18]
                OFF_MAG_INT_SRC: st_nxt.rdata = mag_int_flags; // [RULE17]
                default: st_nxt.rdata = 8'h00;
            endcase
            // Hybrid auto-increment wraps the data burst back to its start
            if (sensor_mode == SENSOR_HYBRID && hyb_autoinc && reg_addr == OFF_DATA_LAST)
            begin
                st_nxt.next_addr = OFF_DATA_FIRST; // [RULE16]
            end
            else
            begin
                st_nxt.next_addr = reg_addr + 7'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= '{trig_en: TRIG_EN_RESET, mode: MODE_STANDBY, default: '0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign fifo_gated = st_r.gated;
    assign trigger_seen = st_r.trig_seen;
    assign sleep_rate_sel = st_r.sleep_sel; // [RULE7]
    assign burst_next_addr = st_r.next_addr;

    sequence s_trig_arm;
        fifo_mode == FIFO_MODE_TRIGGER && trig_hit;
    endsequence

    trig_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
        s_trig_arm ##1 fifo_mode == FIFO_MODE_TRIGGER |-> fifo_gated && trigger_seen)
        else $error("trigger did not gate fifo"); // [RULE1]
    trig_mask_a: assert property (@(posedge clock) disable iff (!arst_n)
        (st_r.trig_en & ~TRIG_EN_MASK) == 8'h00)
        else $error("reserved trigger bit set"); // [RULE2]
    mode_legal_a: assert property (@(posedge clock) disable iff (!arst_n)
        !active_en |=> st_r.mode == MODE_STANDBY)
        else $error("mode not standby when inactive"); // [RULE5]
    aslp_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
        (rd_mode && $stable(st_r.mode) && st_nxt.mode == st_r.mode) |=> !st_r.aslp)
        else $error("auto-sleep bit not cleared"); // [RULE6]
    wake_go_a: assert property (@(posedge clock) disable iff (!arst_n)
        (st_r.mode == MODE_SLEEP && active_en && wake_event) |=> st_r.mode == MODE_WAKE && st_r.aslp)
        else $error("sleep to wake missed"); // [RULE7]
    vecm_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        (rd_src && !(vecm_event && vecm_int_en) && !trans_src_rd && st_r.trans) |=> !st_r.vecm && st_r.trans)
        else $error("summary read clear wrong"); // [RULE8]
    fifo_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
        fifo_status_rd && !(fifo_cond && fifo_sample_in) |=> !st_r.fifo)
        else $error("fifo bit not cleared"); // [RULE9]
    fifo_setwin_a: assert property (@(posedge clock) disable iff (!arst_n)
        fifo_status_rd && fifo_cond && fifo_sample_in |=> st_r.fifo)
        else $error("fifo sample lost to read"); // [RULE20]
    fifo_rearm_a: assert property (@(posedge clock) disable iff (!arst_n)
        (st_r.fifo_cond_pend && fifo_cond && fifo_sample_in && !fifo_status_rd) |=> st_r.fifo)
        else $error("fifo bit not re-armed"); // [RULE20]
    trans_set_a: assert property (@(posedge clock) disable iff (!arst_n)
        trans_event_active && trans_int_en |=> st_r.trans)
        else $error("transient bit missed"); // [RULE10]
    orient_set_a: assert property (@(posedge clock) disable iff (!arst_n)
        orient_new_change && orient_int_en |=> st_r.orient)
        else $error("orientation bit missed"); // [RULE11]
    pulse_clr_a: assert property (@(posedge clock) disable iff (!arst_n)
        pulse_src_rd && !(pulse_event_active && pulse_int_en) |=> !st_r.pulse)
        else $error("pulse bit not cleared"); // [RULE12]
    ffmt_set_a: assert property (@(posedge clock) disable iff (!arst_n)
        ffmt_event_active && ffmt_int_en |=> st_r.ffmt)
        else $error("freefall bit missed"); // [RULE13]
    drdy_hyb_a: assert property (@(posedge clock) disable iff (!arst_n)
        sensor_mode == SENSOR_HYBRID && mag_new |=> st_r.drdy)
        else $error("hybrid data ready missed"); // [RULE14]
    drdy_clr_a: assert property (@(posedge clock) disable iff (!arst_n)
        sensor_mode == SENSOR_ACCEL && accel_data_rd && !accel_new |=> !st_r.drdy)
        else $error("data ready not cleared"); // [RULE15]
    burst_wrap_a: assert property (@(posedge clock) disable iff (!arst_n)
        reg_rd && reg_addr == OFF_DATA_LAST && sensor_mode == SENSOR_HYBRID && hyb_autoinc
        |=> burst_next_addr == OFF_DATA_FIRST)
        else $error("burst did not wrap"); // [RULE16]
    mag_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        reg_rd && reg_addr == OFF_MAG_INT_SRC |=> reg_rdata == $past(mag_int_flags))
        else $error("magnetic flags misread"); // [RULE17]
    src_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        rd_src |=> reg_rdata == $past(src_view))
        else $error("summary readback wrong"); // [RULE18]
    gate_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
        fifo_count == 6'h00 && !gate_error_evt |=> !gate_error)
        else $error("gate error not cleared"); // [RULE3]
endmodule : sensor_event_status_regs
`default_nettype wire

// ### verif/host_model.sv
/*
 * Host processor model: issues register writes and reads on the strobe port.
 * Assumes one-cycle strobes taken at a rising edge and read data one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clock,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end

    task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : write_reg

    // Data is taken at the edge after the strobe edge, before it drops to 0
    task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask : read_reg
endmodule : host_model
`default_nettype wire

// ### verif/sensor_event_status_regs_test.sv
/*
 * Self-checking bench for the sensor event status registers.
 * Assumes the host model drives the register port; detector inputs come from here.
 */
`timescale 1ns/1ps
`default_nettype none
module sensor_event_status_regs_test
    import sensor_event_pkg::*;
;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr, reg_rd;
    logic [6:0] reg_addr, burst_next_addr;
    logic [7:0] reg_wdata, reg_rdata, rd;
    logic [7:0] mag_int_flags = 8'h00;
    logic [7:0] aslp_count = 8'h02;
    logic active_en = 1'b0, aslp_en = 1'b0, activity = 1'b0, hyb_autoinc = 1'b0;
    logic [1:0] fifo_mode = 2'h0, sensor_mode = 2'h0;
    logic fifo_overflow = 1'b0, fifo_watermark = 1'b0, vecm_int_en = 1'b0;
    logic [5:0] fifo_count = 6'h00;
    // Strobes: tick, gate err, sample, fifo rd, a new, m new, a rd, m rd, vecm, wake, src reads
    logic [13:0] pl = 14'h0000;
    // Detector index: 0 freefall, 1 pulse, 2 orientation, 3 transient
    logic [3:0] evt = 4'h0, ien = 4'h0;
    logic fifo_gated, trigger_seen, sleep_rate_sel;
    int err_count = 0;
    int comparisons = 0;

    always #2.5 clock = ~clock;

    host_model host_model_i (.clock(clock), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    sensor_event_status_regs sensor_event_status_regs_i (.clock(clock), .arst_n(arst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .mag_int_flags(mag_int_flags), .active_en(active_en),
        .aslp_en(aslp_en), .aslp_count(aslp_count), .odr_tick(pl[0]), .activity(activity),
        .wake_event(pl[9]), .fifo_mode(fifo_mode), .fifo_overflow(fifo_overflow),
        .fifo_watermark(fifo_watermark), .fifo_sample_in(pl[2]), .fifo_count(fifo_count),
        .gate_error_evt(pl[1]), .sensor_mode(sensor_mode), .hyb_autoinc(hyb_autoinc),
        .accel_new(pl[4]), .mag_new(pl[5]), .accel_data_rd(pl[6]), .mag_data_rd(pl[7]),
        .trans_event_active(evt[3]), .trans_int_en(ien[3]), .trans_src_rd(pl[13]),
        .orient_new_change(evt[2]), .orient_int_en(ien[2]), .orient_detail_reg_rd(pl[12]),
        .pulse_event_active(evt[1]), .pulse_int_en(ien[1]), .pulse_src_rd(pl[11]),
        .ffmt_event_active(evt[0]), .ffmt_int_en(ien[0]), .ffmt_src_rd(pl[10]),
        .vecm_event(pl[8]), .vecm_int_en(vecm_int_en), .fifo_status_rd(pl[3]),
        .fifo_gated(fifo_gated), .trigger_seen(trigger_seen),
        .sleep_rate_sel(sleep_rate_sel), .burst_next_addr(burst_next_addr));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    task automatic strobe(input int i);
        @(posedge clock);
        pl[i] <= 1'b1;
        @(posedge clock);
        pl[i] <= 1'b0;
    endtask : strobe

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        host_model_i.read_reg(a, rd);
        check(rd, exp);
    endtask : rd_chk

    // Strobe then look at the summary after the status bit has settled
    task automatic step(input int i, input logic [7:0] exp);
        strobe(i);
        cyc(1);
        rd_chk(OFF_INT_SRC, exp);
    endtask : step

    // Hang guard well beyond the longest sequence
    initial
    begin
        #200000;
        err_count++;
        conclude();
    end

    initial
    begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        rd_chk(OFF_TRIG_EN, TRIG_EN_RESET);
        rd_chk(OFF_SYS_MODE, 8'h00);
        rd_chk(OFF_INT_SRC, 8'h00);
        host_model_i.write_reg(OFF_TRIG_EN, 8'hff);
        host_model_i.write_reg(OFF_SYS_MODE, 8'hff);
        rd_chk(OFF_TRIG_EN, TRIG_EN_MASK);
        rd_chk(OFF_SYS_MODE, 8'h00);
        rd_chk(7'h7f, 8'h00);
        mag_int_flags <= 8'ha5;
        rd_chk(OFF_MAG_INT_SRC, 8'ha5);
        rd_chk(OFF_INT_SRC, 8'h00);
        host_model_i.write_reg(OFF_TRIG_EN, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            evt[k] <= 1'b1;
            cyc(2);
            rd_chk(OFF_INT_SRC, 8'h00);
            ien[k] <= 1'b1;
            cyc(2);
            rd_chk(OFF_INT_SRC, 8'h04 << k);
            rd_chk(OFF_INT_SRC, 8'h04 << k);
            evt[k] <= 1'b0;
            step(10 + k, 8'h00);
            ien[k] <= 1'b0;
        end
        vecm_int_en <= 1'b1;
        step(8, 8'h02);
        rd_chk(OFF_INT_SRC, 8'h00);
        sensor_mode <= SENSOR_MAG;
        step(4, 8'h00);
        step(5, 8'h01);
        step(6, 8'h01);
        step(7, 8'h00);
        sensor_mode <= SENSOR_ACCEL;
        step(5, 8'h00);
        step(4, 8'h01);
        step(7, 8'h01);
        step(6, 8'h00);
        sensor_mode <= SENSOR_HYBRID;
        step(4, 8'h01);
        step(6, 8'h01);
        step(7, 8'h00);
        step(5, 8'h01);
        step(7, 8'h00);
        hyb_autoinc <= 1'b1;
        rd_chk(OFF_INT_SRC, 8'h00);
        cyc(1);
        check({1'b0, burst_next_addr}, {1'b0, OFF_DATA_FIRST});
        hyb_autoinc <= 1'b0;
        sensor_mode <= SENSOR_ACCEL;
        fifo_watermark <= 1'b1;
        cyc(2);
        rd_chk(OFF_INT_SRC, 8'h40);
        step(3, 8'h00);
        rd_chk(OFF_INT_SRC, 8'h00);
        step(2, 8'h40);
        fifo_watermark <= 1'b0;
        fifo_overflow <= 1'b1;
        step(3, 8'h00);
        step(2, 8'h40);
        fifo_overflow <= 1'b0;
        strobe(3);
        step(2, 8'h00);
        // Sample entering in the status read cycle must keep the bit
        fifo_watermark <= 1'b1;
        @(posedge clock);
        pl[3:2] <= 2'b11;
        @(posedge clock);
        pl[3:2] <= 2'b00;
        fifo_watermark <= 1'b0;
        rd_chk(OFF_INT_SRC, 8'h40);
        strobe(3);
        host_model_i.write_reg(OFF_TRIG_EN, 8'h20);
        fifo_mode <= FIFO_MODE_TRIGGER;
        evt[2] <= 1'b1;
        ien[2] <= 1'b1;
        cyc(3);
        check({7'h00, fifo_gated}, 8'h00);
        evt[3] <= 1'b1;
        ien[3] <= 1'b1;
        cyc(3);
        check({7'h00, fifo_gated}, 8'h01);
        check({7'h00, trigger_seen}, 8'h01);
        fifo_mode <= 2'h0;
        evt <= 4'h0;
        ien <= 4'h0;
        strobe(12);
        strobe(13);
        cyc(2);
        check({7'h00, fifo_gated}, 8'h00);
        fifo_count <= 6'h05;
        strobe(1);
        repeat (3) strobe(0);
        cyc(1);
        rd_chk(OFF_SYS_MODE, 8'h8c);
        repeat (40) strobe(0);
        rd_chk(OFF_SYS_MODE, 8'hfc);
        fifo_count <= 6'h00;
        cyc(2);
        rd_chk(OFF_SYS_MODE, 8'h00);
        active_en <= 1'b1;
        aslp_en <= 1'b1;
        cyc(2);
        rd_chk(OFF_SYS_MODE, 8'h01);
        repeat (2) strobe(0);
        cyc(1);
        rd_chk(OFF_SYS_MODE, 8'h01);
        repeat (3) strobe(0);
        cyc(1);
        check({7'h00, sleep_rate_sel}, 8'h01);
        rd_chk(OFF_INT_SRC, 8'h80);
        rd_chk(OFF_SYS_MODE, 8'h02);
        rd_chk(OFF_INT_SRC, 8'h00);
        strobe(9);
        cyc(1);
        rd_chk(OFF_SYS_MODE, 8'h01);
        check({7'h00, sleep_rate_sel}, 8'h00);
        rd_chk(OFF_INT_SRC, 8'h00);
        // Activity keeps the idle count at zero, so no sleep
        activity <= 1'b1;
        repeat (5) strobe(0);
        check({7'h00, sleep_rate_sel}, 8'h00);
        activity <= 1'b0;
        rd_chk(OFF_SYS_MODE, 8'h01);
        conclude();
    end
endmodule : sensor_event_status_regs_test
`default_nettype wire
